// file: design/rsr_params.svh
// Constants for the regulator and receiver status register slice.
// Operation
// - Display register 0x15 bits 7:4 show regulated code in effect while regulator runs.
// - Display register reads zero while device is in power-down.
// - Power-up and restore-defaults set regulated level to code 1111 (3.4 V).
// - Setting bit 7 picks source: 0 trim result, 1 software code.
// - Setting bits 6:3 hold software code, effective only when source bit is 1.
// - Code maps linearly: 1111 is 3.4 V, 0101 is 2.4 V, 0.1 V steps.
// - Receiver status 0x17 is read-only; bits 7:4 hold peak signal strength.
// - Peak restarts at message start and on the peak clear command: from zero, or from a sample arriving in that same cycle.
// - Status bits 2:0 show gain reduction, 3 dB per step, 111 is 21 dB.
// - Gain reduction shown combines gain loop, software setting and squelch.
// - Receiver status clears at power-up and on restore-defaults.
`ifndef RSR_PARAMS_SVH
`define RSR_PARAMS_SVH
`define RSR_ADDR_DISPLAY 6'h15
`define RSR_ADDR_SETTING 6'h16
`define RSR_ADDR_RXSTAT 6'h17
`define RSR_SETTING_RST 8'h00
`define RSR_LEVEL_MAX 4'hF
`define RSR_LEVEL_MIN 4'h5
`define RSR_SRC_BIT 7
`define RSR_CODE_HI 6
`define RSR_CODE_LO 3
`define RSR_GAIN_MAX 3'h7
`endif

// file: design/rsr_pkg.sv
// Types for the regulator and receiver status register slice.
package rsr_pkg;
  typedef struct packed {
    logic [3:0] peak;
    logic osc_or_field;
    logic [2:0] gain_cut;
  } rsr_rx_status_t;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rsr_wr_t;
endpackage

// file: design/rsr_regs.sv
// Register slice: supply display, supply setting and receiver status.
`timescale 1ns/10ps
`include "rsr_params.svh"
module rsr_regs
  import rsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rsr_wr_t host_wr,
  input wire logic [5:0] host_raddr,
  output logic [7:0] host_rdata,
  input wire logic restore_defaults,
  input wire logic power_down,
  input wire logic trim_valid,
  input wire logic [3:0] trim_level,
  output logic [3:0] supply_level,
  input wire logic msg_start,
  input wire logic peak_clear,
  input wire logic rssi_valid,
  input wire logic [3:0] rssi_sample,
  input wire logic low_power_target,
  input wire logic osc_stable,
  input wire logic field_detect,
  input wire logic [2:0] automatic_gain_loop,
  input wire logic [2:0] sw_gain_cut,
  input wire logic [2:0] squelch_gain_cut
);

  // ========================================
  // Level-input synchronisers
  // ========================================
  logic [1:0] sync1_r, sync2_r;
  logic [1:0] sync_nxt;
  always_comb sync_nxt = {osc_stable, field_detect};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  function automatic logic [2:0] sat_add3(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    logic [4:0] s;
    s = {2'h0, a} + {2'h0, b} + {2'h0, c};
    sat_add3 = (s > {2'h0, `RSR_GAIN_MAX}) ? `RSR_GAIN_MAX : s[2:0];
  endfunction

  function automatic logic [3:0] clamp_level(input logic [3:0] c);
    clamp_level = (c < `RSR_LEVEL_MIN) ? `RSR_LEVEL_MIN : c;
  endfunction

  // ========================================
  // Register state
  // ========================================
  logic [7:0] setting_r, setting_nxt;
  logic [3:0] trim_r, trim_nxt;
  logic [3:0] level_r, level_nxt;
  rsr_rx_status_t rx_r, rx_nxt;
  logic [7:0] rdata_nxt;

  always_comb begin
    setting_nxt = setting_r;
    trim_nxt = trim_r;
    rx_nxt = rx_r;
    if (host_wr.wr && host_wr.addr == `RSR_ADDR_SETTING) begin
      setting_nxt = {host_wr.wdata[7:3], 3'h0};
    end
    if (trim_valid) begin
      trim_nxt = trim_level;
    end
    // A sample that lands in the clearing cycle already belongs to the new message, so it is kept.
    if (msg_start || peak_clear) begin
      rx_nxt.peak = rssi_valid ? rssi_sample : 4'h0;
    end else if (rssi_valid && rssi_sample > rx_r.peak) begin
      rx_nxt.peak = rssi_sample;
    end
    rx_nxt.osc_or_field = low_power_target ? sync2_r[0] : sync2_r[1];
    rx_nxt.gain_cut = sat_add3(automatic_gain_loop, sw_gain_cut, squelch_gain_cut);
    if (restore_defaults) begin
      setting_nxt = `RSR_SETTING_RST;
      trim_nxt = `RSR_LEVEL_MAX;
      rx_nxt = '0;
    end
    // Codes below 0101 have no defined voltage, so they clamp to the lowest level.
    level_nxt = setting_nxt[`RSR_SRC_BIT] ? clamp_level(setting_nxt[`RSR_CODE_HI:`RSR_CODE_LO])
                                            : trim_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setting_r <= `RSR_SETTING_RST;
      trim_r <= `RSR_LEVEL_MAX;
      level_r <= `RSR_LEVEL_MAX;
      rx_r <= '0;
    end else begin
      setting_r <= setting_nxt;
      trim_r <= trim_nxt;
      level_r <= level_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign supply_level = level_r;

  // ========================================
  // Read port
  // ========================================
  always_comb begin
    case (host_raddr)
      `RSR_ADDR_DISPLAY: rdata_nxt = power_down ? 8'h00 : {level_r, 4'h0};
      `RSR_ADDR_SETTING: rdata_nxt = setting_r;
      `RSR_ADDR_RXSTAT: rdata_nxt = rx_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
    end else begin
      host_rdata <= rdata_nxt;
    end
  end

  // ========================================
  // Checks
  // ========================================
  property p_pd_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    (host_raddr == `RSR_ADDR_DISPLAY && power_down) |=> host_rdata == 8'h00;
  endproperty
  a_pd_zero: assert property (p_pd_zero) else $error("display not zero in power-down");

  property p_disp;
    @(posedge sys_clk) disable iff (!rst_n)
    (host_raddr == `RSR_ADDR_DISPLAY && !power_down) |=> host_rdata == {$past(supply_level), 4'h0};
  endproperty
  a_disp: assert property (p_disp) else $error("display mismatch");

  property p_default;
    @(posedge sys_clk) disable iff (!rst_n)
    restore_defaults |=> supply_level == `RSR_LEVEL_MAX && rx_r == '0 && setting_r == 8'h00;
  endproperty
  a_default: assert property (p_default) else $error("restore-defaults failed");

  property p_src_sw;
    @(posedge sys_clk) disable iff (!rst_n)
    setting_r[`RSR_SRC_BIT] && setting_r[`RSR_CODE_HI:`RSR_CODE_LO] >= `RSR_LEVEL_MIN
      |-> supply_level == setting_r[`RSR_CODE_HI:`RSR_CODE_LO];
  endproperty
  a_src_sw: assert property (p_src_sw) else $error("software level not applied");

  // With the software source held, trim results must not move the level.
  property p_src_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (setting_r[`RSR_SRC_BIT] && !host_wr.wr && !restore_defaults) |=> $stable(supply_level);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("trim disturbed software level");

  property p_level_range;
    @(posedge sys_clk) disable iff (!rst_n)
    setting_r[`RSR_SRC_BIT] |-> supply_level >= `RSR_LEVEL_MIN;
  endproperty
  a_level_range: assert property (p_level_range) else $error("software level below lowest code");

  property p_src_trim;
    @(posedge sys_clk) disable iff (!rst_n)
    (trim_valid && !restore_defaults && !setting_nxt[`RSR_SRC_BIT]) |=> supply_level == $past(trim_level);
  endproperty
  a_src_trim: assert property (p_src_trim) else $error("trim level not applied");

  property p_peak_clr;
    @(posedge sys_clk) disable iff (!rst_n)
    ((msg_start || peak_clear) && !rssi_valid) |=> rx_r.peak == 4'h0;
  endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("peak not cleared");

  property p_peak_take;
    @(posedge sys_clk) disable iff (!rst_n)
    ((msg_start || peak_clear) && rssi_valid && !restore_defaults) |=> rx_r.peak == $past(rssi_sample);
  endproperty
  a_peak_take: assert property (p_peak_take) else $error("peak not restarted from sample");

  property p_peak_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !(msg_start || peak_clear || restore_defaults) |=> rx_r.peak >= $past(rx_r.peak);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peak dropped");

  property p_unused;
    @(posedge sys_clk) disable iff (!rst_n)
    setting_r[2:0] == 3'h0 ##1 (host_raddr == `RSR_ADDR_DISPLAY) [*2] |-> host_rdata[3:0] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");

  property p_gain;
    @(posedge sys_clk) disable iff (!rst_n)
    (!restore_defaults && automatic_gain_loop == 3'h0 && sw_gain_cut == 3'h0 && squelch_gain_cut == 3'h0)
      |=> rx_r.gain_cut == 3'h0;
  endproperty
  a_gain: assert property (p_gain) else $error("gain reduction wrong");

  property p_gain_sat;
    @(posedge sys_clk) disable iff (!rst_n)
    (!restore_defaults && automatic_gain_loop[2] && sw_gain_cut[2]) |=> rx_r.gain_cut == `RSR_GAIN_MAX;
  endproperty
  a_gain_sat: assert property (p_gain_sat) else $error("gain reduction not saturated");

  // Writes aimed at any address other than the setting register must leave the setting untouched.
  property p_ro_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (host_wr.wr && host_wr.addr != `RSR_ADDR_SETTING && !restore_defaults) |=> setting_r == $past(setting_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed setting");

  property p_bit3_field;
    @(posedge sys_clk) disable iff (!rst_n)
    (!restore_defaults && low_power_target) |=> rx_r.osc_or_field == $past(sync2_r[0]);
  endproperty
  a_bit3_field: assert property (p_bit3_field) else $error("field indicator not shown");

  c_pd: cover property (@(posedge sys_clk) disable iff (!rst_n) power_down && host_raddr == `RSR_ADDR_DISPLAY);
  c_sw: cover property (@(posedge sys_clk) disable iff (!rst_n) setting_r[`RSR_SRC_BIT] ##1 trim_valid);
  c_peak: cover property (@(posedge sys_clk) disable iff (!rst_n) rssi_valid ##1 msg_start);
  c_def: cover property (@(posedge sys_clk) disable iff (!rst_n) restore_defaults);
  c_clr_take: cover property (@(posedge sys_clk) disable iff (!rst_n) (msg_start || peak_clear) && rssi_valid);
endmodule

// file: verification/rsr_regs_bench.sv
// Self-checking bench for the supply and receiver status register slice.
`timescale 1ns/10ps
module rsr_regs_bench;
  import rsr_pkg::*;
  logic sys_clk, rst_n, restore_defaults, power_down, trim_valid, msg_start, peak_clear, rssi_valid;
  logic low_power_target, osc_stable, field_detect, rd_req, rd_d;
  logic [5:0] host_raddr;
  logic [7:0] host_rdata, seed;
  logic [3:0] trim_level, supply_level, rssi_sample, lv;
  logic [2:0] automatic_gain_loop, sw_gain_cut, squelch_gain_cut;
  rsr_wr_t host_wr;
  logic [7:0] exp_q[$];
  int err_count, compares;
  rsr_regs u_rsr_regs (.sys_clk, .rst_n, .host_wr, .host_raddr, .host_rdata, .restore_defaults, .power_down,
    .trim_valid, .trim_level, .supply_level, .msg_start, .peak_clear, .rssi_valid, .rssi_sample,
    .low_power_target, .osc_stable, .field_detect, .automatic_gain_loop, .sw_gain_cut, .squelch_gain_cut);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) host_wr <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk) host_wr.wr <= 1'b0;
  endtask
  // The expected value is queued as the address goes out; the monitor pops it two edges later.
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk) host_raddr <= a;
    rd_req <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk) rd_req <= 1'b0;
  endtask
  task automatic rs(input logic [3:0] v);
    @(posedge sys_clk) rssi_valid <= 1'b1;
    rssi_sample <= v;
    @(posedge sys_clk) rssi_valid <= 1'b0;
  endtask
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1) chk(host_rdata, exp_q.pop_front());
    rd_d <= rd_req;
  end
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial begin
    {rst_n, restore_defaults, power_down, trim_valid, msg_start, peak_clear, rssi_valid} = '0;
    {low_power_target, osc_stable, field_detect, rd_req, rd_d, host_raddr, trim_level, rssi_sample} = '0;
    {automatic_gain_loop, sw_gain_cut, squelch_gain_cut} = '0;
    host_wr = '0;
    seed = 8'h07;
    idle(10);
    rst_n <= 1'b1;
    rd(6'h15, 8'hF0);
    rd(6'h16, 8'h00);
    rd(6'h17, 8'h00);
    wr(6'h16, 8'hCF);
    rd(6'h16, 8'hC8);
    rd(6'h15, 8'h90);
    chk({4'h0, supply_level}, 8'h09);
    wr(6'h15, 8'h00);
    wr(6'h17, 8'hFF);
    rd(6'h15, 8'h90);
    rd(6'h17, 8'h00);
    wr(6'h16, 8'h90);
    rd(6'h15, 8'h50);
    wr(6'h16, 8'h28);
    rd(6'h16, 8'h28);
    rd(6'h15, 8'hF0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      lv = 4'(8'h05 + seed % 8'h0B);
      @(posedge sys_clk) trim_valid <= 1'b1;
      trim_level <= lv;
      @(posedge sys_clk) trim_valid <= 1'b0;
      rd(6'h15, {lv, 4'h0});
    end
    @(posedge sys_clk) power_down <= 1'b1;
    rd(6'h15, 8'h00);
    @(posedge sys_clk) power_down <= 1'b0;
    rd(6'h15, {lv, 4'h0});
    rs(4'h3);
    rs(4'h9);
    rs(4'h4);
    rd(6'h17, 8'h90);
    @(posedge sys_clk) msg_start <= 1'b1;
    @(posedge sys_clk) msg_start <= 1'b0;
    rd(6'h17, 8'h00);
    rs(4'h6);
    @(posedge sys_clk) peak_clear <= 1'b1;
    @(posedge sys_clk) peak_clear <= 1'b0;
    rd(6'h17, 8'h00);
    @(posedge sys_clk) peak_clear <= 1'b1;
    rssi_valid <= 1'b1;
    rssi_sample <= 4'h2;
    @(posedge sys_clk) peak_clear <= 1'b0;
    rssi_valid <= 1'b0;
    rd(6'h17, 8'h20);
    @(posedge sys_clk) {automatic_gain_loop, sw_gain_cut, squelch_gain_cut} <= {3'h2, 3'h3, 3'h1};
    idle(2);
    rd(6'h17, 8'h26);
    @(posedge sys_clk) {automatic_gain_loop, sw_gain_cut, squelch_gain_cut} <= {3'h4, 3'h4, 3'h4};
    osc_stable <= 1'b1;
    idle(4);
    rd(6'h17, 8'h2F);
    @(posedge sys_clk) low_power_target <= 1'b1;
    field_detect <= 1'b1;
    osc_stable <= 1'b0;
    idle(4);
    rd(6'h17, 8'h2F);
    @(posedge sys_clk) field_detect <= 1'b0;
    {automatic_gain_loop, sw_gain_cut, squelch_gain_cut} <= '0;
    rs(4'h8);
    wr(6'h16, 8'hC8);
    @(posedge sys_clk) trim_valid <= 1'b1;
    trim_level <= 4'h6;
    @(posedge sys_clk) trim_valid <= 1'b0;
    rd(6'h15, 8'h90);
    @(posedge sys_clk) restore_defaults <= 1'b1;
    @(posedge sys_clk) restore_defaults <= 1'b0;
    rd(6'h17, 8'h00);
    rd(6'h16, 8'h00);
    rd(6'h15, 8'hF0);
    chk({4'h0, supply_level}, 8'h0F);
    rd(6'h3F, 8'h00);
    idle(3);
    wrap_up();
  end
endmodule
